/* common/prr_pkg.sv */
// Constants shared by the pin route unit
package prr_pkg;
  // Register offsets
  localparam logic [2:0] PRR_OFS_EVENT = 3'h0;
  localparam logic [2:0] PRR_OFS_LOGIC = 3'h1;
  localparam logic [2:0] PRR_OFS_UART = 3'h2;
  localparam logic [2:0] PRR_OFS_SPI = 3'h3;
  localparam logic [2:0] PRR_OFS_WIDE = 3'h4;
  localparam logic [2:0] PRR_OFS_NARROW = 3'h5;
  // Reset value and writable bits
  localparam logic [7:0] PRR_RESET = 8'h00;
  localparam logic [7:0] PRR_MASK_EVENT = 8'h03;
  localparam logic [7:0] PRR_MASK_LOGIC = 8'h0f;
  localparam logic [7:0] PRR_MASK_UART = 8'h0f;
  localparam logic [7:0] PRR_MASK_SPI = 8'h03;
  localparam logic [7:0] PRR_MASK_WIDE = 8'h3f;
  localparam logic [7:0] PRR_MASK_NARROW = 8'h03;
  // Field positions
  localparam int PRR_UART0_LSB = 0;
  localparam int PRR_UART1_LSB = 2;
  localparam int PRR_SPI_LSB = 0;
  // Two-bit position codes
  localparam logic [1:0] PRR_CODE_DEFAULT = 2'h0;
  localparam logic [1:0] PRR_CODE_ALT = 2'h1;
  localparam logic [1:0] PRR_CODE_NONE = 2'h3;
  // Pin codes: port A at 0, port B at 8, port C at 16
  localparam logic [4:0] PRR_PA0 = 5'h00;
  localparam logic [4:0] PRR_PA1 = 5'h01;
  localparam logic [4:0] PRR_PA2 = 5'h02;
  localparam logic [4:0] PRR_PA3 = 5'h03;
  localparam logic [4:0] PRR_PA4 = 5'h04;
  localparam logic [4:0] PRR_PA5 = 5'h05;
  localparam logic [4:0] PRR_PA7 = 5'h07;
  localparam logic [4:0] PRR_PB0 = 5'h08;
  localparam logic [4:0] PRR_PB1 = 5'h09;
  localparam logic [4:0] PRR_PB2 = 5'h0a;
  localparam logic [4:0] PRR_PB3 = 5'h0b;
  localparam logic [4:0] PRR_PB4 = 5'h0c;
  localparam logic [4:0] PRR_PB5 = 5'h0d;
  localparam logic [4:0] PRR_PB6 = 5'h0e;
  localparam logic [4:0] PRR_PB7 = 5'h0f;
  localparam logic [4:0] PRR_PC0 = 5'h10;
  localparam logic [4:0] PRR_PC1 = 5'h11;
  localparam logic [4:0] PRR_PC2 = 5'h12;
  localparam logic [4:0] PRR_PC3 = 5'h13;
  localparam logic [4:0] PRR_PC4 = 5'h14;
  localparam logic [4:0] PRR_PC5 = 5'h15;
  // Number of pins and of driving sources
  localparam int PRR_PINS = 24;
  localparam int PRR_SRCS = 23;
endpackage : prr_pkg

/* rtl/prr_pin_route_unit.sv */
// Peripheral pin route unit: routing registers and pin override logic
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Event output B goes to PB2, or PB7 when its bit is set.
// - Event output A goes to PA2, or PA7 when its bit is set.
// - Table 3 output on PC4 or PA5; inputs fixed on PC0 to PC2.
// - Table 2 output on PB3 or PB6; inputs fixed on PB0 to PB2.
// - Table 1 output on PA7 or PC1; inputs fixed on PC3 to PC5.
// - Table 0 output on PA4 or PB4; inputs fixed on PA0 to PA2.
// - Second UART uses bits 3:2; default PA1-PA4, alternate PC2,PC1,PC0,PC3.
// - First UART uses bits 1:0; default PB2,PB3,PB1,PB0, alternate PA1-PA4.
// - UART code 3 disconnects all pins; code 2 is reserved.
// - SPI default PA1-PA4, alternate PC2,PC1,PC0,PC3, code 3 none, 2 reserved.
// - Six wide timer outputs each pick PB0-2/PA3-5 or PB3-5/PC3-5.
// - Second narrow timer output on PA3, or PC4 when bit 1 set.
// - First narrow timer output on PA5, or PC0 when bit 0 set.
// - Each setting enables, disables or moves a peripheral's pins.
module prr_pin_route_unit #(
  parameter int ADDR_W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Event outputs
  input wire logic [1:0] event_out_en,
  input wire logic [1:0] event_out,
  // Logic table outputs and inputs
  input wire logic [3:0] logic_table_en,
  input wire logic [3:0] logic_table_out,
  output logic [11:0] logic_table_in_q,
  // UARTs: index 0 first, 1 second
  input wire logic [1:0] uart_en,
  input wire logic [1:0] uart_txd,
  input wire logic [1:0] uart_clock_pin,
  input wire logic [1:0] uart_direction_pin,
  output logic [1:0] uart_rxd_q,
  // SPI host signals
  input wire logic spi_en,
  input wire logic spi_mosi,
  input wire logic spi_sck,
  input wire logic spi_ss_n,
  output logic spi_miso_q,
  // Timer waveform outputs
  input wire logic [5:0] wide_timer_en,
  input wire logic [5:0] wide_timer_wo,
  input wire logic [1:0] narrow_timer_en,
  input wire logic [1:0] narrow_timer_wo,
  // Pins: bits 7:0 port A, 15:8 port B, 23:16 port C
  input wire logic [prr_pkg::PRR_PINS-1:0] pin_in,
  output logic [prr_pkg::PRR_PINS-1:0] pin_ovr_q,
  output logic [prr_pkg::PRR_PINS-1:0] pin_val_q
);
  import prr_pkg::*;

  logic [7:0] ev_q, lt_q, ua_q, sp_q, wt_q, nt_q;
  logic [PRR_PINS-1:0] sync1_q, sync2_q;
  logic [PRR_PINS-1:0] ovr_d, val_d;
  logic [4:0] src_pin [PRR_SRCS];
  logic [PRR_SRCS-1:0] src_on, src_val;
  logic [1:0] ua0_code, ua1_code, sp_code;
  logic ua0_alt, ua1_alt, sp_alt;
  logic ua0_on, ua1_on, sp_on;
  logic [7:0] rd_mux;
  logic [2:0] a3;

  // Address truncated to the register index
  assign a3 = reg_addr[2:0];

  // Field decode of a two-bit code: connected only for default or alternate
  function automatic logic code_on(input logic [1:0] c);
    code_on = (c == PRR_CODE_DEFAULT) || (c == PRR_CODE_ALT);
  endfunction : code_on

  // Routing registers, cleared on reset, reserved bits masked
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ev_q <= PRR_RESET;
      lt_q <= PRR_RESET;
      ua_q <= PRR_RESET;
      sp_q <= PRR_RESET;
      wt_q <= PRR_RESET;
      nt_q <= PRR_RESET;
    end
    else if (reg_wr)
    begin
      if (a3 == PRR_OFS_EVENT) ev_q <= reg_wdata & PRR_MASK_EVENT;
      if (a3 == PRR_OFS_LOGIC) lt_q <= reg_wdata & PRR_MASK_LOGIC;
      if (a3 == PRR_OFS_UART) ua_q <= reg_wdata & PRR_MASK_UART;
      if (a3 == PRR_OFS_SPI) sp_q <= reg_wdata & PRR_MASK_SPI;
      if (a3 == PRR_OFS_WIDE) wt_q <= reg_wdata & PRR_MASK_WIDE;
      if (a3 == PRR_OFS_NARROW) nt_q <= reg_wdata & PRR_MASK_NARROW;
    end
  end

  // Read selection; unmapped indexes read zero
  assign rd_mux = (a3 == PRR_OFS_EVENT) ? ev_q :
                  (a3 == PRR_OFS_LOGIC) ? lt_q :
                  (a3 == PRR_OFS_UART) ? ua_q :
                  (a3 == PRR_OFS_SPI) ? sp_q :
                  (a3 == PRR_OFS_WIDE) ? wt_q :
                  (a3 == PRR_OFS_NARROW) ? nt_q : PRR_RESET;

  // Read data stands for one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      reg_rdata_q <= PRR_RESET;
    else if (reg_rd)
      reg_rdata_q <= rd_mux;
    else
      reg_rdata_q <= PRR_RESET;
  end

  // Two-flop synchroniser on the pin inputs
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Code fields; reserved code 2 behaves as not connected
  assign ua0_code = ua_q[PRR_UART0_LSB +: 2];
  assign ua1_code = ua_q[PRR_UART1_LSB +: 2];
  assign sp_code = sp_q[PRR_SPI_LSB +: 2];
  assign ua0_on = uart_en[0] && code_on(ua0_code);
  assign ua1_on = uart_en[1] && code_on(ua1_code);
  assign sp_on = spi_en && code_on(sp_code);
  assign ua0_alt = (ua0_code == PRR_CODE_ALT);
  assign ua1_alt = (ua1_code == PRR_CODE_ALT);
  assign sp_alt = (sp_code == PRR_CODE_ALT);

  // Event outputs
  assign src_pin[0] = ev_q[0] ? PRR_PA7 : PRR_PA2;
  assign src_pin[1] = ev_q[1] ? PRR_PB7 : PRR_PB2;
  assign src_on[1:0] = event_out_en;
  assign src_val[1:0] = event_out;

  // Wide timer waveform outputs
  assign src_pin[2] = wt_q[0] ? PRR_PB3 : PRR_PB0;
  assign src_pin[3] = wt_q[1] ? PRR_PB4 : PRR_PB1;
  assign src_pin[4] = wt_q[2] ? PRR_PB5 : PRR_PB2;
  assign src_pin[5] = wt_q[3] ? PRR_PC3 : PRR_PA3;
  assign src_pin[6] = wt_q[4] ? PRR_PC4 : PRR_PA4;
  assign src_pin[7] = wt_q[5] ? PRR_PC5 : PRR_PA5;
  assign src_on[7:2] = wide_timer_en;
  assign src_val[7:2] = wide_timer_wo;

  // Narrow timer waveform outputs
  assign src_pin[8] = nt_q[0] ? PRR_PC0 : PRR_PA5;
  assign src_pin[9] = nt_q[1] ? PRR_PC4 : PRR_PA3;
  assign src_on[9:8] = narrow_timer_en;
  assign src_val[9:8] = narrow_timer_wo;

  // Logic table outputs
  assign src_pin[10] = lt_q[0] ? PRR_PB4 : PRR_PA4;
  assign src_pin[11] = lt_q[1] ? PRR_PC1 : PRR_PA7;
  assign src_pin[12] = lt_q[2] ? PRR_PB6 : PRR_PB3;
  assign src_pin[13] = lt_q[3] ? PRR_PA5 : PRR_PC4;
  assign src_on[13:10] = logic_table_en;
  assign src_val[13:10] = logic_table_out;

  // SPI host outputs
  assign src_pin[14] = sp_alt ? PRR_PC2 : PRR_PA1;
  assign src_pin[15] = sp_alt ? PRR_PC0 : PRR_PA3;
  assign src_pin[16] = sp_alt ? PRR_PC3 : PRR_PA4;
  assign src_on[16:14] = {3{sp_on}};
  assign src_val[16:14] = {spi_ss_n, spi_sck, spi_mosi};

  // First UART outputs
  assign src_pin[17] = ua0_alt ? PRR_PA1 : PRR_PB2;
  assign src_pin[18] = ua0_alt ? PRR_PA3 : PRR_PB1;
  assign src_pin[19] = ua0_alt ? PRR_PA4 : PRR_PB0;
  assign src_on[19:17] = {3{ua0_on}};
  assign src_val[19:17] = {uart_direction_pin[0], uart_clock_pin[0], uart_txd[0]};

  // Second UART outputs
  assign src_pin[20] = ua1_alt ? PRR_PC2 : PRR_PA1;
  assign src_pin[21] = ua1_alt ? PRR_PC0 : PRR_PA3;
  assign src_pin[22] = ua1_alt ? PRR_PC3 : PRR_PA4;
  assign src_on[22:20] = {3{ua1_on}};
  assign src_val[22:20] = {uart_direction_pin[1], uart_clock_pin[1], uart_txd[1]};

  // Pin claim merge; a later source wins a shared pin
  always_comb
  begin
    ovr_d = '0;
    val_d = '0;
    for (int k = 0; k < PRR_SRCS; k++)
    begin
      if (src_on[k])
      begin
        ovr_d[src_pin[k]] = 1'b1;
        val_d[src_pin[k]] = src_val[k];
      end
    end
  end

  // Registered pin override and input returns to peripherals
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pin_ovr_q <= '0;
      pin_val_q <= '0;
      logic_table_in_q <= '0;
      uart_rxd_q <= 2'h3;
      spi_miso_q <= 1'b0;
    end
    else
    begin
      pin_ovr_q <= ovr_d;
      pin_val_q <= val_d;
      logic_table_in_q <= {sync2_q[PRR_PC0 +: 3], sync2_q[PRR_PB0 +: 3],
                           sync2_q[PRR_PC3 +: 3], sync2_q[PRR_PA0 +: 3]};
      uart_rxd_q[0] <= !ua0_on ? 1'b1 : (ua0_alt ? sync2_q[PRR_PA2] : sync2_q[PRR_PB3]);
      uart_rxd_q[1] <= !ua1_on ? 1'b1 : (ua1_alt ? sync2_q[PRR_PC1] : sync2_q[PRR_PA2]);
      spi_miso_q <= sp_on && (sp_alt ? sync2_q[PRR_PC1] : sync2_q[PRR_PA2]);
    end
  end

  // Checks on the routing behaviour
  AST_RESET_CLEAR: assert property (@(posedge mclk) !rstn |=> (ev_q == 8'h00) && (ua_q == 8'h00))
    else $error("routing register not cleared by reset");

  AST_EVB_PIN: assert property (@(posedge mclk) disable iff (!rstn)
    event_out_en[1] && !ev_q[1] && ($countones(src_on[22:2]) == 0)
    |=> pin_ovr_q[PRR_PB2] && (pin_val_q[PRR_PB2] == $past(event_out[1])))
    else $error("event output B not on its default pin");

  AST_EVA_ALT: assert property (@(posedge mclk) disable iff (!rstn)
    event_out_en[0] && ev_q[0] && ($countones(src_on[22:2]) == 0)
    |=> pin_ovr_q[PRR_PA7] && !pin_ovr_q[PRR_PA2])
    else $error("event output A not moved to its alternate pin");

  AST_LOGIC_TABLE_3_ALT: assert property (@(posedge mclk) disable iff (!rstn)
    lt_q[3] && logic_table_en[3]
    |=> pin_ovr_q[PRR_PA5] && (pin_val_q[PRR_PA5] == $past(logic_table_out[3])))
    else $error("table 3 output not on its alternate pin");

  AST_LOGIC_TABLE_2_DEF: assert property (@(posedge mclk) disable iff (!rstn)
    !lt_q[2] && logic_table_en[2]
    |=> pin_ovr_q[PRR_PB3] && (pin_val_q[PRR_PB3] == $past(logic_table_out[2])))
    else $error("table 2 output not on its default pin");

  AST_LOGIC_TABLE_1_DEF: assert property (@(posedge mclk) disable iff (!rstn)
    !lt_q[1] && logic_table_en[1]
    |=> pin_ovr_q[PRR_PA7] && (pin_val_q[PRR_PA7] == $past(logic_table_out[1])))
    else $error("table 1 output not on its default pin");

  AST_UART_NONE: assert property (@(posedge mclk) disable iff (!rstn)
    (ua0_code == PRR_CODE_NONE) |=> (uart_rxd_q[0] == 1'b1))
    else $error("disconnected first UART still sees a pin");

  AST_UART1_RX: assert property (@(posedge mclk) disable iff (!rstn)
    uart_en[1] && (ua1_code == PRR_CODE_ALT) |=> (uart_rxd_q[1] == $past(sync2_q[PRR_PC1])))
    else $error("second UART receive not taken from alternate pin");

  AST_SPI_OFF: assert property (@(posedge mclk) disable iff (!rstn)
    (sp_code == PRR_CODE_NONE) ##1 (sp_code == PRR_CODE_NONE) |-> !spi_miso_q)
    else $error("disconnected SPI still sees a pin");

  AST_WIDE_ALT: assert property (@(posedge mclk) disable iff (!rstn)
    wt_q[5] && wide_timer_en[5] && !src_on[13] && !nt_q[1] |=> pin_ovr_q[PRR_PC5])
    else $error("wide timer output 5 not on alternate pin");

  AST_NARROW_DEF: assert property (@(posedge mclk) disable iff (!rstn)
    !nt_q[0] && narrow_timer_en[0] && !(logic_table_en[3] && lt_q[3])
    |=> pin_ovr_q[PRR_PA5] && (pin_val_q[PRR_PA5] == $past(narrow_timer_wo[0])))
    else $error("first narrow timer output not on its default pin");

  AST_NARROW2_ALT: assert property (@(posedge mclk) disable iff (!rstn)
    nt_q[1] && narrow_timer_en[1] && !(logic_table_en[3] && !lt_q[3])
    |=> pin_ovr_q[PRR_PC4] && (pin_val_q[PRR_PC4] == $past(narrow_timer_wo[1])))
    else $error("second narrow timer output not on its alternate pin");

  AST_FREE_PIN: assert property (@(posedge mclk) disable iff (!rstn)
    (src_on == '0) |=> (pin_ovr_q == '0))
    else $error("pin overridden with no claiming source");

  AST_READBACK: assert property (@(posedge mclk) disable iff (!rstn)
    reg_wr && (a3 == PRR_OFS_SPI) ##1 reg_rd && (a3 == PRR_OFS_SPI)
    |=> (reg_rdata_q == ($past(reg_wdata, 2) & PRR_MASK_SPI)))
    else $error("routing register read back wrong");
endmodule : prr_pin_route_unit

`default_nettype wire

/* tb/prr_pin_model.sv */
// Pin side model: the level each package pin shows to the router
`timescale 1ns/1ns
`default_nettype none
module prr_pin_model (
  // Drive from the router
  input wire logic [prr_pkg::PRR_PINS-1:0] pin_ovr_q,
  input wire logic [prr_pkg::PRR_PINS-1:0] pin_val_q,
  // Board levels where nothing on chip drives
  input wire logic [prr_pkg::PRR_PINS-1:0] board_lvl,
  // Resolved pin levels
  output logic [prr_pkg::PRR_PINS-1:0] pin_lvl
);
  import prr_pkg::*;
  // A driven pin shows the router level, any other the board level
  assign pin_lvl = (pin_ovr_q & pin_val_q) | (~pin_ovr_q & board_lvl);
endmodule : prr_pin_model
`default_nettype wire

/* tb/test_peripheral_pin_router.sv */
// Self-checking bench for the peripheral pin router
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin num_errors++; $display("MISMATCH %0t %s", $time, m); end end
module test_peripheral_pin_router;
  import prr_pkg::*;
  // Stimulus levels are fixed, the enables and routes move
  logic mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, s_en = 1'b0, s_mosi = 1'b1, s_sck = 1'b0, s_ss = 1'b1, s_miso;
  logic [2:0] addr = '0;
  logic [7:0] wdata = '0, rdata;
  logic [1:0] ev_en = '0, ev = 2'h1, u_en = '0, u_tx = 2'h3, u_ck = 2'h0, u_dir = 2'h3, n_en = '0, n_wo = 2'h2, u_rx;
  logic [3:0] lt_en = '0, lt = 4'h5;
  logic [5:0] w_en = '0, w_wo = 6'h2d;
  logic [11:0] lt_in;
  logic [23:0] ext = 24'h2c_c396, pins, ovr, val, e_ovr, e_val;
  // Serial pin sets: first default, shared, second alternate
  logic [4:0] p_q [3][4] = '{'{PRR_PB2, PRR_PB3, PRR_PB1, PRR_PB0}, '{PRR_PA1, PRR_PA2, PRR_PA3, PRR_PA4},
    '{PRR_PC2, PRR_PC1, PRR_PC0, PRR_PC3}};
  int num_errors = 0, total_checks = 0;

  prr_pin_route_unit uut (.mclk(mclk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata_q(rdata), .event_out_en(ev_en), .event_out(ev), .logic_table_en(lt_en),
    .logic_table_out(lt), .logic_table_in_q(lt_in), .uart_en(u_en), .uart_txd(u_tx), .uart_clock_pin(u_ck),
    .uart_direction_pin(u_dir), .uart_rxd_q(u_rx), .spi_en(s_en), .spi_mosi(s_mosi), .spi_sck(s_sck),
    .spi_ss_n(s_ss), .spi_miso_q(s_miso), .wide_timer_en(w_en), .wide_timer_wo(w_wo),
    .narrow_timer_en(n_en), .narrow_timer_wo(n_wo), .pin_in(pins), .pin_ovr_q(ovr), .pin_val_q(val));
  prr_pin_model pm (.pin_ovr_q(ovr), .pin_val_q(val), .board_lvl(ext), .pin_lvl(pins));

  // Clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // Register port cycles
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e, "register read")
  endtask : rreg
  // Write then read the same index with no gap between the strobes
  task automatic wrback(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e, "register read back")
  endtask : wrback

  // Expected pin bookkeeping
  task automatic claim(input int p, input logic v);
    e_ovr[p] = 1'b1;
    e_val[p] = v;
  endtask : claim
  task automatic quad(input int j);
    claim(p_q[j][0], 1'b1);
    claim(p_q[j][2], 1'b0);
    claim(p_q[j][3], 1'b1);
  endtask : quad
  function automatic logic lvl(input int p);
    return e_ovr[p] ? e_val[p] : ext[p];
  endfunction : lvl
  task automatic pin_chk();
    repeat (5) @(posedge mclk);
    #1;
    `CHK(ovr, e_ovr, "pin claim")
    `CHK(val, e_val, "pin level")
  endtask : pin_chk

  // Reset values, writable bits, unmapped slots, reset in mid-run
  task automatic test_regs();
    logic [7:0] msk [8] = '{PRR_MASK_EVENT, PRR_MASK_LOGIC, PRR_MASK_UART, PRR_MASK_SPI, PRR_MASK_WIDE,
      PRR_MASK_NARROW, 8'h00, 8'h00};
    for (int a = 0; a < 8; a++) rreg(a[2:0], PRR_RESET);
    for (int a = 0; a < 8; a++)
    begin
      wrback(a[2:0], 8'hff, msk[a]);
    end
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) rreg(a[2:0], PRR_RESET);
    $display("test registers done");
  endtask : test_regs

  // Event outputs on every route setting
  task automatic test_event();
    @(posedge mclk);
    ev_en <= 2'h3;
    for (int r = 0; r < 4; r++)
    begin
      wreg(PRR_OFS_EVENT, 8'(r));
      e_ovr = '0;
      e_val = '0;
      claim(r[0] ? PRR_PA7 : PRR_PA2, 1'b1);
      claim(r[1] ? PRR_PB7 : PRR_PB2, 1'b0);
      pin_chk();
    end
    @(posedge mclk);
    ev_en <= '0;
    $display("test event done");
  endtask : test_event

  // Table outputs on all sixteen settings, inputs on fixed pins
  task automatic test_tables();
    @(posedge mclk);
    lt_en <= 4'hf;
    for (int r = 0; r < 16; r++)
    begin
      wreg(PRR_OFS_LOGIC, 8'(r));
      e_ovr = '0;
      e_val = '0;
      claim(r[0] ? PRR_PB4 : PRR_PA4, 1'b1);
      claim(r[1] ? PRR_PC1 : PRR_PA7, 1'b0);
      claim(r[2] ? PRR_PB6 : PRR_PB3, 1'b1);
      claim(r[3] ? PRR_PA5 : PRR_PC4, 1'b0);
      pin_chk();
      `CHK(lt_in, {lvl(PRR_PC2), lvl(PRR_PC1), lvl(PRR_PC0), lvl(PRR_PB2), lvl(PRR_PB1), lvl(PRR_PB0), lvl(PRR_PC5), lvl(PRR_PC4), lvl(PRR_PC3), lvl(PRR_PA2), lvl(PRR_PA1), lvl(PRR_PA0)}, "table inputs")
    end
    @(posedge mclk);
    lt_en <= '0;
    $display("test tables done");
  endtask : test_tables

  // Each UART through default, alternate and none, the other parked
  task automatic test_uart();
    logic [1:0] c;
    int j;
    logic rx;
    @(posedge mclk);
    u_en <= 2'h3;
    for (int k = 0; k < 6; k++)
    begin
      c = (k % 3 == 2) ? PRR_CODE_NONE : 2'(k % 3);
      j = (k < 3 ? 0 : 1) + int'(c[0]);
      wreg(PRR_OFS_UART, k < 3 ? {4'h0, 2'h3, c} : {4'h0, c, 2'h3});
      e_ovr = '0;
      e_val = '0;
      if (c != PRR_CODE_NONE) quad(j);
      rx = (c == PRR_CODE_NONE) ? 1'b1 : lvl(p_q[j][1]);
      pin_chk();
      `CHK(u_rx, k < 3 ? {1'b1, rx} : {rx, 1'b1}, "uart receive")
    end
    @(posedge mclk);
    u_en <= '0;
    $display("test uart done");
  endtask : test_uart

  // SPI through default, alternate and none
  task automatic test_spi();
    logic [1:0] c;
    @(posedge mclk);
    s_en <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      c = (k == 2) ? PRR_CODE_NONE : 2'(k);
      wreg(PRR_OFS_SPI, {6'h00, c});
      e_ovr = '0;
      e_val = '0;
      if (c != PRR_CODE_NONE) quad(1 + k);
      pin_chk();
      `CHK(s_miso, (c == PRR_CODE_NONE) ? 1'b0 : lvl(p_q[1 + k][1]), "spi receive")
    end
    @(posedge mclk);
    s_en <= 1'b0;
    $display("test spi done");
  endtask : test_spi

  // Wide timer per-bit routes, then the narrow timers
  task automatic test_timers();
    logic [4:0] wd [6] = '{PRR_PB0, PRR_PB1, PRR_PB2, PRR_PA3, PRR_PA4, PRR_PA5};
    logic [4:0] wa [6] = '{PRR_PB3, PRR_PB4, PRR_PB5, PRR_PC3, PRR_PC4, PRR_PC5};
    logic [5:0] rs [3] = '{6'h00, 6'h3f, 6'h15};
    @(posedge mclk);
    w_en <= 6'h3f;
    for (int i = 0; i < 3; i++)
    begin
      wreg(PRR_OFS_WIDE, {2'h0, rs[i]});
      e_ovr = '0;
      e_val = '0;
      for (int b = 0; b < 6; b++) claim(rs[i][b] ? wa[b] : wd[b], w_wo[b]);
      pin_chk();
    end
    @(posedge mclk);
    w_en <= '0;
    n_en <= 2'h3;
    for (int r = 0; r < 4; r++)
    begin
      wreg(PRR_OFS_NARROW, 8'(r));
      e_ovr = '0;
      e_val = '0;
      claim(r[0] ? PRR_PC0 : PRR_PA5, 1'b0);
      claim(r[1] ? PRR_PC4 : PRR_PA3, 1'b1);
      pin_chk();
    end
    $display("test timers done");
  endtask : test_timers

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    test_regs();
    test_event();
    test_tables();
    test_uart();
    test_spi();
    test_timers();
    end_sim();
  end
endmodule : test_peripheral_pin_router
`default_nettype wire
